// ---- tsl_pkg.sv ----
// Constants, register map and types of the triggered sample logger readout.
// How it works
// (R1) Scaled readout adds the bias to each stored sample, then multiplies by gain.
// (R2) The scaled result is rounded to nearest and saturated to signed 8 bits.
// (R3) Each lane read transfers exactly one byte per channel and sample.
// (R4) The displayed byte total is held between 200 and 32000.
// (R5) Readout starts at the written start index, relative to the trigger position.
// (R6) Mode code 0x03 stops the trigger logic; host writes it before reconfiguring.
// (R7) Stopping during free or rearming sampling gives status 0x03, else 0x00 while initialising; host waits for it.
// (R8) Writing single-shot mode 0x02 moves status to 0x01, waiting for trigger.
// (R9) A matching trigger condition moves status to 0x02, sampling.
// (R10) Status 0x03 is set when single-shot capture completes; host reads then.
// (R11) Channel enable 0x01 includes a channel, 0x00 excludes it; four channels.
// (R12) Coupling 0x01 compares the raw source directly against the level.
// (R13) Slope 0x01 fires when the source crosses the level rising.
// (R14) Divider 1 samples every base tick; larger values slow proportionally.
// (R15) The level compared is the one matching the source width.
// (R16) Trigger delay 0 starts storing exactly at the trigger event.
// (R17) Modes: 0x00 free running, 0x01 rearming, 0x02 single shot, 0x03 stop.
// (R18) Coupling 0x00 ac, 0x01 dc, 0x02 bit mask on the set mask bits.
// (R19) Slope 0x01 rising, 0x02 falling, 0x03 both; mask 0-to-1 is rising.
// (R20) Signed delay gives samples kept before trigger; negative postpones capture.
// (R21) Each read of a lane returns that channel's next sample from the start index.
package tsl_pkg;
    localparam int ADDR_W = 14;
    localparam int MEM_DEPTH = 8192;
    localparam int PTR_W = 13;
    localparam int GAIN_FRAC = 16;
    // Register indexes; byte address is four times the index
    localparam logic [11:0] IDX_RATE = 12'h6d6;
    localparam logic [11:0] IDX_BASE = 12'h6d7;
    localparam logic [11:0] IDX_DEPTH = 12'h6d8;
    localparam logic [11:0] IDX_CH_ON = 12'h6d9;
    localparam logic [11:0] IDX_CH_SRC_LO = 12'h6da;
    localparam logic [11:0] IDX_MODE = 12'h6db;
    localparam logic [11:0] IDX_FIRE_SRC = 12'h6dc;
    localparam logic [11:0] IDX_COUPLING = 12'h6dd;
    localparam logic [11:0] IDX_EDGE = 12'h6de;
    localparam logic [11:0] IDX_THR_BYTE = 12'h6df;
    localparam logic [11:0] IDX_THR_HALF = 12'h6e0;
    localparam logic [11:0] IDX_THR_TRI = 12'h6e1;
    localparam logic [11:0] IDX_THR_WORD = 12'h6e2;
    localparam logic [11:0] IDX_THR_SINGLE = 12'h6e3;
    localparam logic [11:0] IDX_THR_WIDE_LO = 12'h6e4;
    localparam logic [11:0] IDX_PRETRIG = 12'h6e5;
    localparam logic [11:0] IDX_STATUS = 12'h6e7;
    localparam logic [11:0] IDX_GAIN = 12'h6e8;
    localparam logic [11:0] IDX_BIAS = 12'h6e9;
    localparam logic [11:0] IDX_START = 12'h6ea;
    localparam logic [11:0] IDX_LANE0 = 12'h6eb;
    localparam logic [11:0] IDX_LANE3 = 12'h6ee;
    localparam logic [11:0] IDX_DISP_TOTAL = 12'h6ef;
    localparam logic [11:0] IDX_CH_SRC_HI = 12'h6f0;
    localparam logic [11:0] IDX_THR_WIDE_HI = 12'h6f1;
    // Reset values
    localparam logic [15:0] RST_RATE = 16'h0001;
    localparam logic [31:0] RST_BASE = 32'h0000_26c0;
    localparam logic [15:0] RST_DEPTH = 16'h01f4;
    localparam logic [15:0] RST_CH_SRC = 16'h03e8;
    localparam logic [15:0] RST_FIRE_SRC = 16'h03e8;
    localparam logic [15:0] RST_DISP_TOTAL = 16'h01f4;
    localparam logic [31:0] RST_GAIN = 32'h0001_0000;
    // Limits
    localparam logic [15:0] DEPTH_MIN = 16'h01f4;
    localparam logic [15:0] DEPTH_MAX = 16'h1f40;
    localparam logic [15:0] DISP_MIN = 16'h00c8;
    localparam logic [15:0] DISP_MAX = 16'h7d00;
    // Mode, coupling and channel enable codes
    localparam logic [7:0] MODE_FREE = 8'h00;
    localparam logic [7:0] MODE_NORMAL = 8'h01;
    localparam logic [7:0] MODE_SINGLE = 8'h02;
    localparam logic [7:0] MODE_STOP = 8'h03;
    localparam logic [7:0] CPL_AC = 8'h00;
    localparam logic [7:0] CPL_DC = 8'h01;
    localparam logic [7:0] CPL_MASK = 8'h02;
    localparam logic [7:0] CH_ON_CODE = 8'h01;
    // Source width codes
    localparam logic [1:0] SW_8 = 2'h0;
    localparam logic [1:0] SW_16 = 2'h1;
    localparam logic [1:0] SW_24 = 2'h2;
    typedef enum logic [1:0] {
        tsl_st_init,
        tsl_st_wait,
        tsl_st_sampling,
        tsl_st_ready
    } tsl_status_t;
endpackage : tsl_pkg

// ---- tsl_logger.sv ----
// Triggered four-channel sample logger with APB registers and scaled byte readout.
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
module tsl_logger (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [tsl_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic base_tick,
    input wire logic [31:0] source_value,
    input wire logic [1:0] source_width,
    input wire logic [31:0] sample_ch0,
    input wire logic [31:0] sample_ch1,
    input wire logic [31:0] sample_ch2,
    input wire logic [31:0] sample_ch3,
    output logic [15:0] fire_source_out,
    output logic [15:0] chan_source_0,
    output logic [15:0] chan_source_1,
    output logic [15:0] chan_source_2,
    output logic [15:0] chan_source_3
);
    import tsl_pkg::*;

    // Sign-extend a source or level by its width code
    function automatic logic signed [31:0] sext(input logic [31:0] v, input logic [1:0] w);
        case (w)
            SW_8: sext = {{24{v[7]}}, v[7:0]};
            SW_16: sext = {{16{v[15]}}, v[15:0]};
            SW_24: sext = {{8{v[23]}}, v[23:0]};
            default: sext = v;
        endcase
    endfunction : sext

    // Bias, gain (16 fraction bits), round to nearest, saturate to a signed byte
    function automatic logic [7:0] scale_byte(input logic signed [31:0] s,
                                              input logic signed [31:0] b,
                                              input logic signed [31:0] g);
        logic signed [32:0] sum;
        logic signed [65:0] prod;
        logic signed [49:0] q;
        sum = {s[31], s} + {b[31], b};
        prod = sum * g;
        prod = prod + 66'sh0_0000_0000_0000_8000;
        q = prod[65:GAIN_FRAC];
        if (q > 50'sh0_0000_0000_007f) begin
            scale_byte = 8'h7f;
        end else if (q < -50'sh0_0000_0000_0080) begin
            scale_byte = 8'h80;
        end else begin
            scale_byte = q[7:0];
        end
    endfunction : scale_byte

    // Fold a signed position into the ring of the given depth
    function automatic logic [PTR_W-1:0] wrap(input logic signed [31:0] v,
                                              input logic [15:0] depth);
        logic signed [31:0] d;
        logic signed [31:0] r;
        d = {16'h0000, depth};
        r = v % d;
        if (r < 0) begin
            r = r + d;
        end
        wrap = r[PTR_W-1:0];
    endfunction : wrap

    // Level crossing detector for the chosen slopes
    function automatic logic crossed(input logic signed [31:0] prv,
                                     input logic signed [31:0] cur,
                                     input logic signed [31:0] lvl,
                                     input logic [1:0] edges);
        crossed = (edges[0] && prv < lvl && cur >= lvl) ||
                  (edges[1] && prv >= lvl && cur < lvl);
    endfunction : crossed

    // Software-visible registers
    logic [15:0] rate_divider;
    logic [15:0] capture_depth;
    logic [3:0] channel_on;
    logic [15:0] chan_src [0:3];
    logic [7:0] arm_mode;
    logic [15:0] fire_source_select;
    logic [7:0] fire_coupling_select;
    logic [7:0] fire_edge_select;
    logic [7:0] fire_threshold_byte;
    logic [15:0] fire_threshold_half;
    logic [23:0] fire_threshold_tri;
    logic [31:0] fire_threshold_word;
    logic [31:0] fire_threshold_single;
    logic [63:0] fire_threshold_wide;
    logic [15:0] pretrigger_count;
    logic [31:0] readout_gain;
    logic [31:0] readout_bias;
    logic [15:0] readout_start_index;
    logic [15:0] displayed_sample_total;

    // Capture state
    tsl_status_t arm_state;
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] trig_ptr;
    logic [15:0] remain;
    logic [15:0] delay_cnt;
    logic [15:0] div_cnt;
    logic signed [31:0] prev_src;
    logic signed [31:0] prev_diff;
    logic [15:0] rd_cnt [0:3];
    logic [31:0] mem [0:3][0:MEM_DEPTH-1];

    // Bus decode; one wait state, write and read side effects at the pready edge
    wire [11:0] idx = paddr[ADDR_W-1:2];
    wire xfer_done = psel && penable && pready;
    wire wr_en = xfer_done && pwrite;
    wire rd_en = xfer_done && !pwrite;
    wire mode_wr = wr_en && idx == IDX_MODE;
    wire start_wr = wr_en && idx == IDX_START;
    wire lane_hit = idx >= IDX_LANE0 && idx <= IDX_LANE3;
    wire [11:0] lane_ofs = idx - IDX_LANE0;
    wire [1:0] lane = lane_ofs[1:0];
    wire captured = arm_state == tsl_st_ready;

    // Divided sample tick; a divider of 0 acts as 1
    wire [15:0] div_last = (rate_divider == 16'h0000) ? 16'h0000 : rate_divider - 16'h0001;
    wire tick = base_tick && div_cnt == div_last; // [R14]

    // Trigger source and level of matching width, ac uses the change per sample
    wire signed [31:0] cur_src = sext(source_value, source_width);
    wire [31:0] lvl_raw = (source_width == SW_8) ? {24'h00_0000, fire_threshold_byte} :
                          (source_width == SW_16) ? {16'h0000, fire_threshold_half} :
                          (source_width == SW_24) ? {8'h00, fire_threshold_tri} :
                          fire_threshold_word; // [R15]
    wire signed [31:0] lvl = sext(lvl_raw, source_width);
    wire signed [31:0] cur_diff = cur_src - prev_src;
    wire [31:0] mask_rise = ~prev_src & cur_src & lvl_raw;
    wire [31:0] mask_fall = prev_src & ~cur_src & lvl_raw;
    wire fire_dc = crossed(prev_src, cur_src, lvl, fire_edge_select[1:0]); // [R12] [R13]
    wire fire_ac = crossed(prev_diff, cur_diff, lvl, fire_edge_select[1:0]);
    wire fire_mask = (fire_edge_select[0] && mask_rise != 32'h0000_0000) ||
                     (fire_edge_select[1] && mask_fall != 32'h0000_0000); // [R19]
    wire fire = (fire_coupling_select == CPL_DC) ? fire_dc :
                (fire_coupling_select == CPL_AC) ? fire_ac :
                (fire_coupling_select == CPL_MASK) ? fire_mask : 1'b0; // [R18]

    // Pretrigger handling; negative delay postpones storing past the trigger
    wire pre_neg = pretrigger_count[15];
    wire [15:0] pre_mag = pre_neg ? 16'h0000 - pretrigger_count : pretrigger_count;
    wire [15:0] post_cnt = (capture_depth > pre_mag) ? capture_depth - pre_mag : 16'h0000;
    wire run_store = arm_state == tsl_st_sampling && delay_cnt == 16'h0000 &&
                     (arm_mode == MODE_FREE || remain != 16'h0000);
    wire store_en = tick && !mode_wr && (arm_state == tsl_st_wait || run_store);
    wire [PTR_W-1:0] wr_next = ({3'b000, wr_ptr} + 16'h0001 >= capture_depth) ?
                               '0 : wr_ptr + 1'b1;
    wire capture_done = run_store && arm_mode != MODE_FREE && remain == 16'h0001;
    wire [31:0] samples [0:3];
    assign samples[0] = sample_ch0;
    assign samples[1] = sample_ch1;
    assign samples[2] = sample_ch2;
    assign samples[3] = sample_ch3;

    // Scaled readout of the lane's next sample relative to the trigger
    wire signed [31:0] rd_pos = $signed({{19{1'b0}}, trig_ptr}) +
                                $signed({{16{readout_start_index[15]}}, readout_start_index}) +
                                $signed({16'h0000, rd_cnt[lane]}); // [R5] [R21]
    wire [PTR_W-1:0] rd_addr = wrap(rd_pos, capture_depth);
    wire lane_avail = captured && rd_cnt[lane] < displayed_sample_total; // [R4]
    wire [7:0] lane_byte = scale_byte(mem[lane][rd_addr], readout_bias, readout_gain); // [R1] [R2]

    // Read data selection
    logic [31:0] rd_val;
    logic rd_ok;
    always_comb begin
        rd_ok = 1'b1;
        rd_val = 32'h0000_0000;
        case (idx)
            IDX_RATE: rd_val = {16'h0000, rate_divider};
            IDX_BASE: rd_val = RST_BASE;
            IDX_DEPTH: rd_val = {16'h0000, capture_depth};
            IDX_CH_ON: rd_val = {7'h00, channel_on[3], 7'h00, channel_on[2],
                                 7'h00, channel_on[1], 7'h00, channel_on[0]};
            IDX_CH_SRC_LO: rd_val = {chan_src[1], chan_src[0]};
            IDX_CH_SRC_HI: rd_val = {chan_src[3], chan_src[2]};
            IDX_MODE: rd_val = {24'h00_0000, arm_mode};
            IDX_FIRE_SRC: rd_val = {16'h0000, fire_source_select};
            IDX_COUPLING: rd_val = {24'h00_0000, fire_coupling_select};
            IDX_EDGE: rd_val = {24'h00_0000, fire_edge_select};
            IDX_THR_BYTE: rd_val = {24'h00_0000, fire_threshold_byte};
            IDX_THR_HALF: rd_val = {16'h0000, fire_threshold_half};
            IDX_THR_TRI: rd_val = {8'h00, fire_threshold_tri};
            IDX_THR_WORD: rd_val = fire_threshold_word;
            IDX_THR_SINGLE: rd_val = fire_threshold_single;
            IDX_THR_WIDE_LO: rd_val = fire_threshold_wide[31:0];
            IDX_THR_WIDE_HI: rd_val = fire_threshold_wide[63:32];
            IDX_PRETRIG: rd_val = {16'h0000, pretrigger_count};
            IDX_STATUS: rd_val = {30'h0000_0000, arm_state};
            IDX_GAIN: rd_val = readout_gain;
            IDX_BIAS: rd_val = readout_bias;
            IDX_START: rd_val = {16'h0000, readout_start_index};
            IDX_DISP_TOTAL: rd_val = {16'h0000, displayed_sample_total};
            default: begin
                if (lane_hit) begin
                    rd_val = lane_avail ? {24'h00_0000, lane_byte} : 32'h0000_0000; // [R3]
                end else begin
                    rd_ok = 1'b0;
                end
            end
        endcase
    end

    // APB handshake, registered read data and error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && penable && !pready;
            prdata <= (psel && penable && !pready && !pwrite && rd_ok) ? rd_val : 32'h0000_0000;
            pslverr <= psel && penable && !pready && !rd_ok;
        end
    end

    // Configuration registers with their documented limits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rate_divider <= RST_RATE;
            capture_depth <= RST_DEPTH;
            channel_on <= 4'h0;
            chan_src <= '{RST_CH_SRC, RST_CH_SRC, RST_CH_SRC, RST_CH_SRC};
            fire_source_select <= RST_FIRE_SRC;
            fire_coupling_select <= CPL_DC;
            fire_edge_select <= 8'h01;
            fire_threshold_byte <= 8'h00;
            fire_threshold_half <= 16'h0000;
            fire_threshold_tri <= 24'h00_0000;
            fire_threshold_word <= 32'h0000_0000;
            fire_threshold_single <= 32'h0000_0000;
            fire_threshold_wide <= 64'h0000_0000_0000_0000;
            pretrigger_count <= 16'h0000;
            readout_gain <= RST_GAIN;
            readout_bias <= 32'h0000_0000;
            readout_start_index <= 16'h0000;
            displayed_sample_total <= RST_DISP_TOTAL;
        end else if (wr_en) begin
            case (idx)
                IDX_RATE: rate_divider <= (pwdata[15:0] == 16'h0000) ? RST_RATE : pwdata[15:0];
                IDX_DEPTH: capture_depth <= (pwdata[15:0] < DEPTH_MIN) ? DEPTH_MIN :
                                            (pwdata[15:0] > DEPTH_MAX) ? DEPTH_MAX : pwdata[15:0];
                IDX_CH_ON: channel_on <= {pwdata[31:24] == CH_ON_CODE, pwdata[23:16] == CH_ON_CODE,
                                          pwdata[15:8] == CH_ON_CODE, pwdata[7:0] == CH_ON_CODE};
                IDX_CH_SRC_LO: begin
                    chan_src[0] <= pwdata[15:0];
                    chan_src[1] <= pwdata[31:16];
                end
                IDX_CH_SRC_HI: begin
                    chan_src[2] <= pwdata[15:0];
                    chan_src[3] <= pwdata[31:16];
                end
                IDX_FIRE_SRC: fire_source_select <= pwdata[15:0];
                IDX_COUPLING: fire_coupling_select <= pwdata[7:0];
                IDX_EDGE: fire_edge_select <= pwdata[7:0];
                IDX_THR_BYTE: fire_threshold_byte <= pwdata[7:0];
                IDX_THR_HALF: fire_threshold_half <= pwdata[15:0];
                IDX_THR_TRI: fire_threshold_tri <= pwdata[23:0];
                IDX_THR_WORD: fire_threshold_word <= pwdata;
                IDX_THR_SINGLE: fire_threshold_single <= pwdata;
                IDX_THR_WIDE_LO: fire_threshold_wide[31:0] <= pwdata;
                IDX_THR_WIDE_HI: fire_threshold_wide[63:32] <= pwdata;
                IDX_PRETRIG: pretrigger_count <= pwdata[15:0];
                IDX_GAIN: readout_gain <= pwdata;
                IDX_BIAS: readout_bias <= pwdata;
                IDX_START: readout_start_index <= pwdata[15:0];
                IDX_DISP_TOTAL: displayed_sample_total <= (pwdata[15:0] < DISP_MIN) ? DISP_MIN :
                                    (pwdata[15:0] > DISP_MAX) ? DISP_MAX : pwdata[15:0];
                default: ;
            endcase
        end
    end

    // Rate divider counter, stepped on base ticks, and trigger history, updated on sample ticks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= 16'h0000;
            prev_src <= 32'sh0000_0000;
            prev_diff <= 32'sh0000_0000;
        end else begin
            if (base_tick) begin
                div_cnt <= tick ? 16'h0000 : div_cnt + 16'h0001; // [R14]
            end
            if (tick) begin
                prev_src <= cur_src;
                prev_diff <= cur_diff;
            end
        end
    end

    // Capture sequencing by mode and trigger status
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            arm_mode <= MODE_STOP;
            arm_state <= tsl_st_init;
            wr_ptr <= '0;
            trig_ptr <= '0;
            remain <= 16'h0000;
            delay_cnt <= 16'h0000;
        end else if (mode_wr) begin
            arm_mode <= pwdata[7:0];
            wr_ptr <= '0;
            trig_ptr <= '0;
            delay_cnt <= 16'h0000;
            remain <= 16'h0000;
            case (pwdata[7:0])
                MODE_STOP: begin
                    // Running free or rearming capture keeps its data readable
                    arm_state <= (arm_state == tsl_st_sampling && arm_mode != MODE_SINGLE) ?
                                 tsl_st_ready : tsl_st_init; // [R6] [R7]
                    wr_ptr <= wr_ptr;
                    trig_ptr <= trig_ptr;
                end
                MODE_SINGLE, MODE_NORMAL: arm_state <= tsl_st_wait; // [R8] [R17]
                MODE_FREE: arm_state <= tsl_st_sampling; // [R17]
                default: arm_state <= tsl_st_init;
            endcase
        end else if (tick) begin
            case (arm_state)
                tsl_st_wait: begin
                    wr_ptr <= wr_next;
                    if (fire) begin
                        arm_state <= tsl_st_sampling; // [R9]
                        if (pre_neg) begin
                            delay_cnt <= pre_mag; // [R20]
                            remain <= capture_depth;
                            trig_ptr <= wr_next;
                        end else begin
                            // Trigger sample is stored now, pre samples lie before it
                            trig_ptr <= wr_ptr; // [R16] [R20]
                            remain <= (post_cnt == 16'h0000) ? 16'h0000 : post_cnt - 16'h0001;
                        end
                    end
                end
                tsl_st_sampling: begin
                    if (delay_cnt != 16'h0000) begin
                        delay_cnt <= delay_cnt - 16'h0001;
                    end else if (arm_mode == MODE_FREE) begin
                        wr_ptr <= wr_next;
                        trig_ptr <= wr_next;
                    end else if (remain == 16'h0000 || capture_done) begin
                        wr_ptr <= run_store ? wr_next : wr_ptr;
                        remain <= 16'h0000;
                        // Single shot ends ready, rearming mode waits again
                        arm_state <= (arm_mode == MODE_SINGLE) ? tsl_st_ready : tsl_st_wait; // [R10]
                    end else begin
                        wr_ptr <= wr_next;
                        remain <= remain - 16'h0001;
                    end
                end
                default: ;
            endcase
        end
    end

    // Sample memory, disabled channels store zero
    always_ff @(posedge pclk) begin
        if (store_en) begin
            for (int ch = 0; ch < 4; ch++) begin
                mem[ch][wr_ptr] <= channel_on[ch] ? samples[ch] : 32'h0000_0000; // [R11]
            end
        end
    end

    // Per-lane readout position, restarted by a start index write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_cnt <= '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
        end else if (start_wr) begin
            rd_cnt <= '{16'h0000, 16'h0000, 16'h0000, 16'h0000}; // [R5]
        end else if (rd_en && lane_hit && lane_avail) begin
            rd_cnt[lane] <= rd_cnt[lane] + 16'h0001; // [R21]
        end
    end

    // Source selections handed to the parameter engine
    assign fire_source_out = fire_source_select;
    assign chan_source_0 = chan_src[0];
    assign chan_source_1 = chan_src[1];
    assign chan_source_2 = chan_src[2];
    assign chan_source_3 = chan_src[3];
endmodule : tsl_logger

// ---- tsl_logger_checker.sv ----
// Port assertions for the sample logger register bus and readout.
`timescale 1ns/1ps
module tsl_logger_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [13:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [15:0] fire_source_out
);
    import tsl_pkg::*;
    // Decoded index and completed access
    wire logic [11:0] idx = paddr[13:2];
    wire logic done = psel && penable && pready;
    wire logic rd = done && !pwrite;
    wire logic fsw = done && pwrite && idx == IDX_FIRE_SRC;
    wire logic [15:0] wlo = pwdata[15:0];
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_wait; psel && penable && !pready; endsequence
    property p_ans; s_wait |=> pready; endproperty
    a_ans: assert property (p_ans) else $error("no answer");
    property p_one; pready |=> !pready; endproperty
    a_one: assert property (p_one) else $error("ready held");
    property p_idle; !pready |-> prdata == 32'h0000_0000; endproperty
    a_idle: assert property (p_idle) else $error("stray data");
    property p_lane; rd && idx >= IDX_LANE0 && idx <= IDX_LANE3 |-> prdata[31:8] == 0; endproperty
    a_lane: assert property (p_lane) else $error("lane wider than byte");
    property p_stat; rd && idx == IDX_STATUS |-> prdata[31:2] == 0; endproperty
    a_stat: assert property (p_stat) else $error("bad status");
    property p_base; rd && idx == IDX_BASE |-> prdata == RST_BASE; endproperty
    a_base: assert property (p_base) else $error("bad tick rate");
    property p_src; fsw |=> fire_source_out == $past(wlo); endproperty
    a_src: assert property (p_src) else $error("source not taken");
    property p_hold; !$stable(fire_source_out) |-> $past(fsw); endproperty
    a_hold: assert property (p_hold) else $error("source moved");
    property p_unm; done && idx == 12'h06e6 |-> pslverr; endproperty
    a_unm: assert property (p_unm) else $error("no error");
endmodule : tsl_logger_checker
bind tsl_logger tsl_logger_checker i_chk (.*);

// ---- tsl_logger_tb.sv ----
// Register-level bench for the sample logger readout.
`timescale 1ns/1ps
module tsl_logger_tb;
    import tsl_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, base_tick = 0;
    logic [13:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rdat, source_value = 32'hffff_ffec;
    logic pready, pslverr, rerr;
    logic [15:0] cs0;
    int error_cnt = 0, checks_done = 0;
    logic [11:0] ri [6] = '{IDX_RATE, IDX_BASE, IDX_DEPTH, IDX_MODE, IDX_STATUS, IDX_DISP_TOTAL};
    logic [31:0] re [6] = '{1, RST_BASE, RST_DEPTH, 3, 0, RST_DISP_TOTAL};
    logic [11:0] wi [9] = '{IDX_RATE, IDX_DEPTH, IDX_CH_ON, IDX_COUPLING, IDX_EDGE,
        IDX_THR_WORD, IDX_PRETRIG, IDX_GAIN, IDX_BIAS};
    logic [31:0] wd [9] = '{1, 500, 32'h0000_0101, 1, 1, 0, 0, 32'h0001_8000, 5};
    tsl_logger i_dut (.*, .source_width(2'h3), .sample_ch0(source_value),
        .sample_ch1(source_value), .sample_ch2(source_value), .sample_ch3(source_value),
        .fire_source_out(), .chan_source_0(cs0), .chan_source_1(), .chan_source_2(),
        .chan_source_3());
    // Clock and a ramp that crosses zero while ticking
    initial forever #2 pclk = ~pclk;
    always @(posedge pclk) if (base_tick) source_value <= source_value + 1;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // One APB transfer; read data and error taken at the ready edge
    task automatic xfer(input logic w, input logic [11:0] i, input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= {i, 2'b00};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 40);
        if (pready !== 1'b1) error_cnt++;
        rdat = prdata;
        rerr = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : xfer
    task automatic rd(input logic [11:0] i, input logic [31:0] e);
        xfer(0, i, 0);
        chk(rdat, e);
    endtask : rd
    task automatic poll(input logic [11:0] i, input logic [31:0] e);
        int n = 0;
        do xfer(0, i, 0); while (rdat !== e && ++n < 300);
    endtask : poll
    // Gain 1.5 and bias 5, rounded half up, saturated
    function automatic logic [31:0] eb(input int s);
        int v = ((s + 5) * 3 + 1) / 2;
        return {24'h00_0000, 8'(v > 127 ? 127 : v)};
    endfunction : eb
    task automatic test_done();
        $display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : test_done
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1;
        for (int k = 0; k < 6; k++) rd(ri[k], re[k]);
        xfer(0, 12'h06e6, 0);
        chk({31'h0, rerr}, 1);
        xfer(1, IDX_MODE, 3);
        rd(IDX_STATUS, 0);
        chk(cs0, RST_CH_SRC);
        xfer(1, IDX_CH_SRC_LO, 32'h0002_0007);
        xfer(1, IDX_FIRE_SRC, 32'h0000_0123);
        chk(cs0, 7);
        for (int k = 0; k < 9; k++) xfer(1, wi[k], wd[k]);
        xfer(1, IDX_MODE, 2);
        rd(IDX_STATUS, 1);
        base_tick <= 1;
        poll(IDX_STATUS, 2);
        chk(rdat, 2);
        poll(IDX_STATUS, 3);
        chk(rdat, 3);
        xfer(1, IDX_START, 0);
        for (int k = 0; k < 3; k++) rd(IDX_LANE0, eb(k));
        rd(IDX_LANE0 + 1, eb(0));
        xfer(1, IDX_START, 123);
        rd(IDX_LANE0, eb(123));
        xfer(1, IDX_MODE, 1);
        rd(IDX_STATUS, 1);
        xfer(1, IDX_MODE, 0);
        rd(IDX_STATUS, 2);
        xfer(1, IDX_MODE, 3);
        rd(IDX_STATUS, 3);
        test_done();
    end
    // Watchdog
    initial begin
        #200000;
        error_cnt++;
        test_done();
    end
endmodule : tsl_logger_tb
